/* File: gwts_cfg.svh */
`ifndef GWTS_CFG_SVH
`define GWTS_CFG_SVH
// ============================================================
// register width
`define GWTS_REG_W 16
// ============================================================
// status word bit positions
`define GWTS_USB1_FLAG_BIT 3
`define GWTS_THRMOR_FLAG_BIT 1
`define GWTS_THERMAL_ALERT_PIN_FLAG_BIT 0
// ============================================================
// enable word bit positions
`define GWTS_USB_CTL_ONE_WAKE_ENABLE_BIT 3
`define GWTS_THERMAL_POLARITY_SELECT_BIT 2
`define GWTS_THERMAL_EVENT_ENABLE_BIT 0
// ============================================================
// reset values
`define GWTS_STS_RESET 16'h0000
`define GWTS_EN_RESET 16'h0000
// ============================================================
// default width of the duty ratio code
`define GWTS_DUTY_W 3
`endif

/* File: gwts_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checker for the status slice
module gwts_checker #(
  parameter int DUTY_W = 3
) (
  // clock, reset, writes
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic sts_wr,
  input wire logic [15:0] sts_wdata,
  input wire logic en_wr,
  // sources
  input wire logic usb_ctl_one_wake_req,
  input wire logic thermal_override_event,
  input wire logic thermal_alert_pin,
  input wire logic sci_route_sel,
  input wire logic [DUTY_W-1:0] thermal_duty_ratio,
  // results
  input wire logic [15:0] sts_rdata,
  input wire logic [15:0] en_rdata,
  input wire logic wake_event,
  input wire logic system_control_interrupt,
  input wire logic system_mgmt_interrupt,
  input wire logic throttle_active,
  input wire logic [DUTY_W-1:0] throttle_ratio
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // flags that no write clears this cycle
  logic [15:0] keep;
  assign keep = sts_rdata & ~(sts_wr ? sts_wdata : 16'h0000);
  // override seen at an edge
  sequence s_ovr;
    thermal_override_event;
  endsequence
  a_usb_sets: assert property (usb_ctl_one_wake_req |=> sts_rdata[3]) else $error("usb flag not set");
  a_ovr_sets: assert property (s_ovr |=> sts_rdata[1]) else $error("override flag not set");
  a_pin_sets: assert property (
    thermal_alert_pin == en_rdata[2] && !en_wr |=> sts_rdata[0])
    else $error("pin");
  a_flags_hold: assert property (
    1'h1 |=> (sts_rdata & $past(keep)) == $past(keep))
    else $error("flag lost");
  a_clear_works: assert property (
    sts_wr && sts_wdata[3] && !usb_ctl_one_wake_req |=> !sts_rdata[3])
    else $error("clr");
  a_wake_gated: assert property (wake_event == (sts_rdata[3] && en_rdata[3])) else $error("wake gate");
  a_sci_route: assert property (
    system_control_interrupt == (sts_rdata[0] && en_rdata[0] && $past(sci_route_sel)))
    else $error("sci level");
  a_smi_route: assert property (
    system_mgmt_interrupt == (sts_rdata[0] && en_rdata[0] && !$past(sci_route_sel)))
    else $error("smi level");
  a_throttle_on: assert property (
    s_ovr |=> throttle_active && throttle_ratio == $past(thermal_duty_ratio))
    else $error("throttle");
endmodule
bind gwts_top gwts_checker #(.DUTY_W(DUTY_W)) gwts_checker_i (
  .mclk(mclk),
  .reset_n(reset_n),
  .sts_wr(sts_wr),
  .sts_wdata(sts_wdata),
  .en_wr(en_wr),
  .usb_ctl_one_wake_req(usb_ctl_one_wake_req),
  .thermal_override_event(thermal_override_event),
  .thermal_alert_pin(thermal_alert_pin),
  .sci_route_sel(sci_route_sel),
  .thermal_duty_ratio(thermal_duty_ratio),
  .sts_rdata(sts_rdata),
  .en_rdata(en_rdata),
  .wake_event(wake_event),
  .system_control_interrupt(system_control_interrupt),
  .system_mgmt_interrupt(system_mgmt_interrupt),
  .throttle_active(throttle_active),
  .throttle_ratio(throttle_ratio)
);
`default_nettype wire

/* File: gwts_pkg.sv */
`default_nettype none
// ============================================================
// shared types
package gwts_pkg;
  // one 16-bit register word
  typedef logic [15:0] gwts_word_t;
  // where a power-management event is delivered
  typedef enum logic {
    gwts_route_smi,
    gwts_route_sci
  } gwts_route_t;
endpackage
`default_nettype wire

/* File: gwts_src.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// thermal sensor stand-in
module gwts_src (
  // request from the bench
  input wire logic hot,
  input wire logic act_high,
  // pin toward the block
  output logic thermal_alert_pin
);
  // a cold sensor shows the inactive level, never a stale one
  assign thermal_alert_pin = hot ? act_high : !act_high;
endmodule
`default_nettype wire

/* File: gwts_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gwts_cfg.svh"

module gwts_top #(
  parameter int DUTY_W = `GWTS_DUTY_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // status register access
  input wire logic sts_wr,
  input wire logic [`GWTS_REG_W-1:0] sts_wdata,
  output logic [`GWTS_REG_W-1:0] sts_rdata,
  // enable register access
  input wire logic en_wr,
  input wire logic [`GWTS_REG_W-1:0] en_wdata,
  output logic [`GWTS_REG_W-1:0] en_rdata,
  // event sources
  input wire logic usb_ctl_one_wake_req,
  input wire logic thermal_override_event,
  input wire logic thermal_alert_pin,
  // event routing and throttling
  input wire logic sci_route_sel,
  input wire logic [DUTY_W-1:0] thermal_duty_ratio,
  // event outputs
  output logic wake_event,
  output logic system_control_interrupt,
  output logic system_mgmt_interrupt,
  output logic throttle_active,
  output logic [DUTY_W-1:0] throttle_ratio
);

  // ============================================================
  // elaboration checks
  // a duty code wider than a byte is not served by the throttle hand-off
  if (DUTY_W < 1 || DUTY_W > 8) begin : g_bad_duty
    $error("gwts_top: DUTY_W must lie in 1..8");
  end
  // the wake flag, wake enable and polarity positions must land inside the word
  if (`GWTS_USB1_FLAG_BIT >= `GWTS_REG_W || `GWTS_USB_CTL_ONE_WAKE_ENABLE_BIT >= `GWTS_REG_W ||
      `GWTS_THERMAL_POLARITY_SELECT_BIT >= `GWTS_REG_W) begin : g_bad_bits
    $error("gwts_top: a bit position lies outside the register word");
  end

  // ============================================================
  // reset images
  // typed copies let each flop take its own bit by plain index
  localparam gwts_pkg::gwts_word_t STS_RST = `GWTS_STS_RESET; // status word after reset
  localparam gwts_pkg::gwts_word_t EN_RST = `GWTS_EN_RESET; // enable word after reset

  // ============================================================
  // state
  // status flags
  logic usb_ctl_one_wake_flag_ff; // wake record, bit 3
  logic thermal_override_flag_ff; // override record, bit 1
  logic thermal_input_flag_ff; // thermal pin record, bit 0
  // enable bits
  logic usb_ctl_one_wake_enable_ff; // enable bit 3
  logic thermal_polarity_select_ff; // enable bit 2
  logic thermal_event_enable_ff; // enable bit 0
  // event outputs and throttle hand-off
  logic wake_event_ff; // registered wake output
  logic sci_ff; // registered sci output
  logic smi_ff; // registered smi output
  logic throttle_active_ff; // override level seen
  logic [DUTY_W-1:0] throttle_ratio_ff; // ratio latched on override
  // next values, one per flop
  logic nxt_usb_ctl_one_wake_flag;
  logic nxt_thermal_override_flag;
  logic nxt_thermal_input_flag;
  logic nxt_usb_ctl_one_wake_enable;
  logic nxt_thermal_polarity_select;
  logic nxt_thermal_event_enable;
  logic nxt_wake_event;
  logic nxt_sci;
  logic nxt_smi;
  logic nxt_throttle_active;
  logic [DUTY_W-1:0] nxt_throttle_ratio;
  logic thermal_pin_active; // pin at selected level
  gwts_pkg::gwts_route_t route; // current delivery target

  // ============================================================
  // next-value logic
  // one pass, so set-over-clear and the outputs see the same next values
  always_comb begin
    // polarity zero means a low pin is active
    thermal_pin_active = (thermal_alert_pin == thermal_polarity_select_ff);
    // route is taken in the same cycle as the flag it delivers
    route = sci_route_sel ? gwts_pkg::gwts_route_sci : gwts_pkg::gwts_route_smi;

    // enables are plain read/write
    nxt_usb_ctl_one_wake_enable = usb_ctl_one_wake_enable_ff;
    nxt_thermal_polarity_select = thermal_polarity_select_ff;
    nxt_thermal_event_enable = thermal_event_enable_ff;
    // reserved enable bits are dropped and read back as zero
    if (en_wr) begin
      nxt_usb_ctl_one_wake_enable = en_wdata[`GWTS_USB_CTL_ONE_WAKE_ENABLE_BIT];
      nxt_thermal_polarity_select = en_wdata[`GWTS_THERMAL_POLARITY_SELECT_BIT];
      nxt_thermal_event_enable = en_wdata[`GWTS_THERMAL_EVENT_ENABLE_BIT];
    end

    // hold by default so a flag outlives its cause
    nxt_usb_ctl_one_wake_flag = usb_ctl_one_wake_flag_ff;
    nxt_thermal_override_flag = thermal_override_flag_ff;
    nxt_thermal_input_flag = thermal_input_flag_ff;
    // write-one-to-clear; zero bits leave flags alone
    if (sts_wr) begin
      if (sts_wdata[`GWTS_USB1_FLAG_BIT]) begin
        nxt_usb_ctl_one_wake_flag = 1'b0;
      end
      if (sts_wdata[`GWTS_THRMOR_FLAG_BIT]) begin
        nxt_thermal_override_flag = 1'b0;
      end
      if (sts_wdata[`GWTS_THERMAL_ALERT_PIN_FLAG_BIT]) begin
        nxt_thermal_input_flag = 1'b0;
      end
    end
    // sets come last so an event in the clear cycle is kept
    // a level source sets its flag again every cycle it stays active
    if (usb_ctl_one_wake_req) begin
      nxt_usb_ctl_one_wake_flag = 1'b1;
    end
    if (thermal_override_event) begin
      nxt_thermal_override_flag = 1'b1;
    end
    if (thermal_pin_active) begin
      nxt_thermal_input_flag = 1'b1;
    end

    // wake follows the stored flag, gated by its enable
    nxt_wake_event = nxt_usb_ctl_one_wake_flag & nxt_usb_ctl_one_wake_enable;
    // only the thermal input flag reaches sci/smi; override never does
    nxt_sci = 1'b0;
    nxt_smi = 1'b0;
    if (nxt_thermal_input_flag && nxt_thermal_event_enable) begin
      unique case (route)
        gwts_pkg::gwts_route_sci: nxt_sci = 1'b1;
        gwts_pkg::gwts_route_smi: nxt_smi = 1'b1;
      endcase
    end

    // override starts throttling at the programmed ratio
    nxt_throttle_active = thermal_override_event;
    nxt_throttle_ratio = throttle_ratio_ff;
    if (thermal_override_event) begin
      nxt_throttle_ratio = thermal_duty_ratio;
    end
  end

  // ============================================================
  // registers
  // sync reset: status and enable flops return to their images, outputs and throttle to zero, on a low edge
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      // status flags
      usb_ctl_one_wake_flag_ff <= STS_RST[`GWTS_USB1_FLAG_BIT];
      thermal_override_flag_ff <= STS_RST[`GWTS_THRMOR_FLAG_BIT];
      thermal_input_flag_ff <= STS_RST[`GWTS_THERMAL_ALERT_PIN_FLAG_BIT];
      // enable bits
      usb_ctl_one_wake_enable_ff <= EN_RST[`GWTS_USB_CTL_ONE_WAKE_ENABLE_BIT];
      thermal_polarity_select_ff <= EN_RST[`GWTS_THERMAL_POLARITY_SELECT_BIT];
      thermal_event_enable_ff <= EN_RST[`GWTS_THERMAL_EVENT_ENABLE_BIT];
      // event outputs and throttle
      wake_event_ff <= 1'b0;
      sci_ff <= 1'b0;
      smi_ff <= 1'b0;
      throttle_active_ff <= 1'b0;
      throttle_ratio_ff <= '0;
    end else begin
      // status flags
      usb_ctl_one_wake_flag_ff <= nxt_usb_ctl_one_wake_flag;
      thermal_override_flag_ff <= nxt_thermal_override_flag;
      thermal_input_flag_ff <= nxt_thermal_input_flag;
      // enable bits
      usb_ctl_one_wake_enable_ff <= nxt_usb_ctl_one_wake_enable;
      thermal_polarity_select_ff <= nxt_thermal_polarity_select;
      thermal_event_enable_ff <= nxt_thermal_event_enable;
      // event outputs and throttle
      wake_event_ff <= nxt_wake_event;
      sci_ff <= nxt_sci;
      smi_ff <= nxt_smi;
      throttle_active_ff <= nxt_throttle_active;
      throttle_ratio_ff <= nxt_throttle_ratio;
    end
  end

  // ============================================================
  // read-back; unused and reserved bits read zero
  always_comb begin
    // status word
    sts_rdata = '0;
    sts_rdata[`GWTS_USB1_FLAG_BIT] = usb_ctl_one_wake_flag_ff;
    sts_rdata[`GWTS_THRMOR_FLAG_BIT] = thermal_override_flag_ff;
    sts_rdata[`GWTS_THERMAL_ALERT_PIN_FLAG_BIT] = thermal_input_flag_ff;
    // enable word
    en_rdata = '0;
    en_rdata[`GWTS_USB_CTL_ONE_WAKE_ENABLE_BIT] = usb_ctl_one_wake_enable_ff;
    en_rdata[`GWTS_THERMAL_POLARITY_SELECT_BIT] = thermal_polarity_select_ff;
    en_rdata[`GWTS_THERMAL_EVENT_ENABLE_BIT] = thermal_event_enable_ff;
  end

  // ============================================================
  // outputs straight from flops
  // no combinational path runs from any input to these pins
  assign wake_event = wake_event_ff;
  assign system_control_interrupt = sci_ff;
  assign system_mgmt_interrupt = smi_ff;
  assign throttle_active = throttle_active_ff;
  assign throttle_ratio = throttle_ratio_ff;

endmodule
`default_nettype wire

/* File: tb_gwts_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("[ERR] %0t mismatch got %h exp %h", $time, (g), (e)); \
  end \
end
module tb_gwts_top;
  // ==========
  // stimulus, results and reference state
  logic mclk = '0, reset_n = '0, sts_wr = '0, en_wr = '0, usb_ctl_one_wake_req = '0, thermal_override_event = '0;
  logic hot = '0, act_high = '0, sci_route_sel = '0, m_thr = '0, pend = '0, thermal_alert_pin;
  logic wake_event, system_control_interrupt, system_mgmt_interrupt, throttle_active;
  logic [15:0] sts_wdata = '0, en_wdata = '0, s = 16'h0019, m_sts = '0, m_en = '0, sts_rdata, en_rdata;
  logic [2:0] thermal_duty_ratio = '0, m_rat = '0, throttle_ratio;
  logic [38:0] q[$], e;
  int errors = 0, n_checks = 0, cyc = 0;
  gwts_top gwts_top_i (
    .mclk(mclk), .reset_n(reset_n), .sts_wr(sts_wr), .sts_wdata(sts_wdata), .sts_rdata(sts_rdata),
    .en_wr(en_wr), .en_wdata(en_wdata), .en_rdata(en_rdata),
    .usb_ctl_one_wake_req(usb_ctl_one_wake_req), .thermal_override_event(thermal_override_event),
    .thermal_alert_pin(thermal_alert_pin), .sci_route_sel(sci_route_sel),
    .thermal_duty_ratio(thermal_duty_ratio), .wake_event(wake_event),
    .system_control_interrupt(system_control_interrupt), .system_mgmt_interrupt(system_mgmt_interrupt),
    .throttle_active(throttle_active), .throttle_ratio(throttle_ratio)
  );
  gwts_src gwts_src_i (.hot(hot), .act_high(act_high), .thermal_alert_pin(thermal_alert_pin));
  initial forever #2.5 mclk = ~mclk;
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // ==========
  // one cycle of stimulus, then its predicted outcome
  task automatic step(input logic rst, input logic [15:0] r);
    @(posedge mclk);
    #1;
    reset_n = !rst;
    sts_wr = r[0] & r[1];
    en_wr = r[2] & r[3];
    sts_wdata = {r[7:0], r[15:8]};
    en_wdata = r;
    usb_ctl_one_wake_req = r[4];
    thermal_override_event = r[5] & r[6];
    hot = r[7];
    act_high = r[8];
    sci_route_sel = r[9];
    thermal_duty_ratio = r[12:10];
    #1;
    // set beats clear; polarity is the value held before this write
    if (rst) begin
      {m_sts, m_en, m_thr, m_rat} = '0;
    end else begin
      m_sts = (m_sts & ~(sts_wr ? sts_wdata & 16'h000B : 16'h0000)) |
        {12'h000, usb_ctl_one_wake_req, 1'h0, thermal_override_event, thermal_alert_pin == m_en[2]};
      if (en_wr) m_en = en_wdata & 16'h000D;
      m_thr = thermal_override_event;
      if (m_thr) m_rat = thermal_duty_ratio;
    end
    q.push_back({m_sts[3] & m_en[3], m_sts[0] & m_en[0] & sci_route_sel, m_sts[0] & m_en[0] & !sci_route_sel,
      m_thr, m_rat, m_en, m_sts});
  endtask
  // ==========
  // watcher: oldest note against what the outputs show
  always @(posedge mclk) begin
    #3;
    if (pend) begin
      e = q.pop_front();
      `CHK(sts_rdata, e[15:0])
      `CHK(en_rdata, e[31:16])
      `CHK({throttle_active, throttle_ratio}, e[35:32])
      `CHK({wake_event, system_control_interrupt, system_mgmt_interrupt}, e[38:36])
    end
    pend = q.size() != 0;
    cyc++;
    // hang guard, well past the ~410 cycles of the run
    if (cyc > 1000) begin
      errors++;
      results();
    end
  end
  task automatic results();
    if (errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========
  // reset, then random traffic with rare resets in mid-run
  initial begin
    // reset_n starts low, so two steps give three low edges
    for (int i = 0; i < 2; i++) step(1'h1, s);
    repeat (400) begin
      s = lfsr(s);
      step(s[15:12] == 4'h0, s);
    end
    repeat (2) @(posedge mclk);
    results();
  end
endmodule
`default_nettype wire
